// file: design/modem_host_strobe.v
`timescale 1ns/1ps
`default_nettype none
`include "quad_modem_regs.vh"

module modem_host_strobe (
  // clock and reset
  input  wire        mclk_i,
  input  wire        rst_i,
  // mode, reset and interrupt select pins
  input  wire        bus_primary_i,
  input  wire        reset_pin_i,
  input  wire        intsel_i,
  // host strobe bus
  input  wire        chip_select_n_i,
  input  wire [4:0]  register_channel_address_i,
  input  wire        rw_strobe_i,
  input  wire [7:0]  host_data_bus_i,
  output reg  [7:0]  host_data_bus_o,
  output reg         host_data_bus_oe_o,
  // axi4-lite write
  input  wire        awvalid_i,
  input  wire [7:0]  awaddr_i,
  output reg         awready_o,
  input  wire        wvalid_i,
  input  wire [31:0] wdata_i,
  input  wire [3:0]  wstrb_i,
  output reg         wready_o,
  output reg         bvalid_o,
  output reg  [1:0]  bresp_o,
  input  wire        bready_i,
  // axi4-lite read
  input  wire        arvalid_i,
  input  wire [7:0]  araddr_i,
  output reg         arready_o,
  output reg         rvalid_o,
  output reg  [31:0] rdata_o,
  output reg  [1:0]  rresp_o,
  input  wire        rready_i,
  // modem inputs, one bit per channel
  input  wire [3:0]  cts_n_i,
  input  wire [3:0]  dsr_n_i,
  input  wire [3:0]  ring_indicator_n_i,
  input  wire [3:0]  carrier_detect_n_i,
  input  wire [3:0]  rx_i,
  // modem outputs, one bit per channel, plus one shared request
  output reg  [3:0]  dtr_n_o,
  output reg  [3:0]  rts_n_o,
  output reg  [3:0]  tx_o,
  output reg  [3:0]  int_o,
  output reg  [3:0]  int_oe_o,
  output reg         irq_n_o
);

  // pin synchronisers, first stage
  reg        mode_s1;
  reg        rpin_s1;
  reg        isel_s1;
  reg        cs_s1;
  reg [4:0]  addr_s1;
  reg        rw_s1;
  reg [7:0]  data_s1;
  reg [3:0]  cts_s1;
  reg [3:0]  dsr_s1;
  reg [3:0]  ring_s1;
  reg [3:0]  carr_s1;
  reg [3:0]  rx_s1;
  // second stage, read by logic together with rw_d, the strobe one flop later for edges
  reg        mode_s2;
  reg        rpin_s2;
  reg        isel_s2;
  reg        cs_s2;
  reg [4:0]  addr_s2;
  reg        rw_s2;
  reg [7:0]  data_s2;
  reg [3:0]  cts_s2;
  reg [3:0]  dsr_s2;
  reg [3:0]  ring_s2;
  reg [3:0]  carr_s2;
  reg [3:0]  rx_s2;
  reg        rw_d;

  // handshake and strobe pins pass two flops before any logic
  always @(posedge mclk_i) begin
    if (rst_i) begin
      mode_s1 <= 1'b0;
      rpin_s1 <= 1'b0;
      isel_s1 <= 1'b0;
      cs_s1   <= 1'b1;
      addr_s1 <= 5'h00;
      rw_s1   <= 1'b1;
      data_s1 <= `BYTE_RESET;
      cts_s1  <= `NIB_ONES;
      dsr_s1  <= `NIB_ONES;
      ring_s1 <= `NIB_ONES;
      carr_s1 <= `NIB_ONES;
      rx_s1   <= `NIB_ONES;
      mode_s2 <= 1'b0;
      rpin_s2 <= 1'b0;
      isel_s2 <= 1'b0;
      cs_s2   <= 1'b1;
      addr_s2 <= 5'h00;
      rw_s2   <= 1'b1;
      data_s2 <= `BYTE_RESET;
      cts_s2  <= `NIB_ONES;
      dsr_s2  <= `NIB_ONES;
      ring_s2 <= `NIB_ONES;
      carr_s2 <= `NIB_ONES;
      rx_s2   <= `NIB_ONES;
      rw_d    <= 1'b1;
    end else begin
      mode_s1 <= bus_primary_i;
      rpin_s1 <= reset_pin_i;
      isel_s1 <= intsel_i;
      cs_s1   <= chip_select_n_i;
      addr_s1 <= register_channel_address_i;
      rw_s1   <= rw_strobe_i;
      data_s1 <= host_data_bus_i;
      cts_s1  <= cts_n_i;
      dsr_s1  <= dsr_n_i;
      ring_s1 <= ring_indicator_n_i;
      carr_s1 <= carrier_detect_n_i;
      rx_s1   <= rx_i;
      mode_s2 <= mode_s1;
      rpin_s2 <= rpin_s1;
      isel_s2 <= isel_s1;
      cs_s2   <= cs_s1;
      addr_s2 <= addr_s1;
      rw_s2   <= rw_s1;
      data_s2 <= data_s1;
      cts_s2  <= cts_s1;
      dsr_s2  <= dsr_s1;
      ring_s2 <= ring_s1;
      carr_s2 <= carr_s1;
      rx_s2   <= rx_s1;
      rw_d    <= rw_s2;
    end
  end

  // device reset: pin polarity follows the bus mode
  wire       dev_rst = rst_i | (mode_s2 ? rpin_s2 : ~rpin_s2);
  wire       alt_mode = ~mode_s2;

  // strobe edges, alternate mode only
  wire       host_wr = alt_mode & rw_d & ~rw_s2 & ~cs_s2 & ~dev_rst;
  wire       host_rd = alt_mode & ~rw_d & rw_s2 & ~cs_s2 & ~dev_rst;
  wire [5:0] host_idx = {1'b0, addr_s2};

  // flattened per-channel state for the read mux
  wire [31:0] ier_all;
  wire [31:0] control_all;
  wire [31:0] status_all;
  wire [31:0] spr_all;
  wire [3:0]  pend_all;
  // receive input reads idle while the device is in reset
  wire [3:0]  rx_live = dev_rst ? `NIB_ONES : rx_s2;

  function idx_mapped;
    input [5:0] idx;
    begin
      if (idx == `IDX_PIN_STATUS)
        idx_mapped = 1'b1;
      else if (idx > `IDX_PIN_STATUS)
        idx_mapped = 1'b0;
      else
        idx_mapped = (idx[2:0] == `REG_IER) | (idx[2:0] == `REG_MODEM_CTRL) |
                     (idx[2:0] == `REG_MODEM_STAT) | (idx[2:0] == `REG_SPR);
    end
  endfunction

  function [7:0] read_byte;
    input [5:0] idx;
    reg   [4:0] base;
    begin
      base = {idx[4:3], 3'h0};
      if (idx == `IDX_PIN_STATUS)
        read_byte = {rx_live, 2'h0, dev_rst, mode_s2};
      else if (!idx_mapped(idx))
        read_byte = `BYTE_RESET;
      else begin
        case (idx[2:0])
          `REG_IER: read_byte = ier_all[base +: 8];
          `REG_MODEM_CTRL: read_byte = control_all[base +: 8];
          `REG_MODEM_STAT: read_byte = status_all[base +: 8];
          default:  read_byte = spr_all[base +: 8];
        endcase
      end
    end
  endfunction

  // axi4-lite slave; one write and one read in flight at most
  reg  [5:0] aw_idx;
  reg  [7:0] w_byte;
  reg        w_lane0;
  // a strobe write takes the port first; the axi write waits one cycle
  wire       axi_wr = ~awready_o & ~wready_o & ~bvalid_o & ~host_wr;
  wire       axi_wr_ok = axi_wr & idx_mapped(aw_idx);
  wire       axi_wr_go = axi_wr_ok & w_lane0 & ~dev_rst &
                         (aw_idx != `IDX_PIN_STATUS);
  wire       axi_rd = arvalid_i & arready_o;
  wire [5:0] ar_idx = araddr_i[7:2];

  always @(posedge mclk_i) begin
    if (rst_i) begin
      awready_o <= 1'b1;
      wready_o  <= 1'b1;
      bvalid_o  <= 1'b0;
      bresp_o   <= `RESP_OKAY;
      aw_idx    <= 6'h00;
      w_byte    <= `BYTE_RESET;
      w_lane0   <= 1'b0;
      arready_o <= 1'b1;
      rvalid_o  <= 1'b0;
      rdata_o   <= {`RDATA_PAD, `BYTE_RESET};
      rresp_o   <= `RESP_OKAY;
    end else begin
      if (awvalid_i && awready_o) begin
        awready_o <= 1'b0;
        aw_idx    <= awaddr_i[7:2];
      end
      if (wvalid_i && wready_o) begin
        wready_o <= 1'b0;
        w_byte   <= wdata_i[7:0];
        w_lane0  <= wstrb_i[0];
      end
      if (axi_wr) begin
        bvalid_o <= 1'b1;
        bresp_o  <= axi_wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid_o && bready_i) begin
        bvalid_o  <= 1'b0;
        awready_o <= 1'b1;
        wready_o  <= 1'b1;
      end
      if (axi_rd) begin
        arready_o <= 1'b0;
        rvalid_o  <= 1'b1;
        rdata_o   <= {`RDATA_PAD, read_byte(ar_idx)};
        rresp_o   <= idx_mapped(ar_idx) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (rvalid_o && rready_i) begin
        rvalid_o  <= 1'b0;
        arready_o <= 1'b1;
      end
    end
  end

  // single write port shared by both paths
  wire       wr_go   = host_wr | axi_wr_go;
  wire [5:0] wr_idx  = host_wr ? host_idx : aw_idx;
  wire [7:0] wr_data = host_wr ? data_s2 : w_byte;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : chan
      reg  [7:0] ier;
      reg  [7:0] modem_control_reg;
      reg  [7:0] spr;
      reg  [3:0] delta;
      reg  [3:0] prev;
      // active-low levels: carrier, ring, set ready, clear to send
      wire [3:0] cur = {carr_s2[g], ring_s2[g], dsr_s2[g], cts_s2[g]};
      wire [3:0] chg = {prev[3] ^ cur[3],
                        ~prev[2] & cur[2],
                        prev[1] ^ cur[1],
                        prev[0] ^ cur[0]};
      wire       sel_w = wr_go & (wr_idx[4:3] == g);
      wire       clr = (host_rd & (host_idx[4:3] == g) &
                        (host_idx[2:0] == `REG_MODEM_STAT)) |
                       (axi_rd & (ar_idx < `IDX_PIN_STATUS) &
                        (ar_idx[4:3] == g) & (ar_idx[2:0] == `REG_MODEM_STAT));
      wire       pend = ier[`IER_MODEM_BIT] & (|delta);

      // status: inverted pin levels high, sticky change flags low
      assign status_all[8*g +: 8] = {~cur, delta};
      assign ier_all[8*g +: 8] = ier;
      assign control_all[8*g +: 8] = modem_control_reg;
      assign spr_all[8*g +: 8] = spr;
      assign pend_all[g] = pend;

      always @(posedge mclk_i) begin
        if (dev_rst) begin
          ier          <= `BYTE_RESET;
          modem_control_reg <= `BYTE_RESET;
          spr          <= `BYTE_RESET;
          delta        <= 4'h0;
          // no change is reported for levels already present at release
          prev         <= cur;
          dtr_n_o[g]   <= 1'b1;
          rts_n_o[g]   <= 1'b1;
          tx_o[g]      <= 1'b1;
          int_o[g]     <= 1'b0;
          int_oe_o[g]  <= 1'b0;
        end else begin
          if (sel_w && wr_idx[2:0] == `REG_IER)
            ier <= wr_data;
          if (sel_w && wr_idx[2:0] == `REG_MODEM_CTRL)
            modem_control_reg <= wr_data;
          if (sel_w && wr_idx[2:0] == `REG_SPR)
            spr <= wr_data;
          prev <= cur;
          // a change in the clearing cycle still lands
          delta <= (delta & ~{4{clr}}) | chg;
          // handshake outputs follow software only
          dtr_n_o[g]  <= ~modem_control_reg[`CTRL_DTR_BIT];
          rts_n_o[g]  <= ~modem_control_reg[`CTRL_RTS_BIT];
          // no transmitter lives here, so the line stays at idle
          tx_o[g]     <= 1'b1;
          int_o[g]    <= mode_s2 & pend;
          int_oe_o[g] <= mode_s2 & (modem_control_reg[`CTRL_INT_EN_BIT] | isel_s2);
        end
      end
    end
  endgenerate

  // alternate mode: channels share one active-low request
  always @(posedge mclk_i) begin
    if (dev_rst)
      irq_n_o <= 1'b1;
    else
      irq_n_o <= ~(alt_mode & (|pend_all));
  end

  // host read path: drive while the strobe stays high and chip is selected
  always @(posedge mclk_i) begin
    if (dev_rst) begin
      host_data_bus_o    <= `BYTE_RESET;
      host_data_bus_oe_o <= 1'b0;
    end else if (host_rd) begin
      host_data_bus_o    <= read_byte(host_idx);
      host_data_bus_oe_o <= 1'b1;
    end else if (!alt_mode || cs_s2 || !rw_s2) begin
      host_data_bus_oe_o <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// file: design/quad_modem_regs.vh
`ifndef QUAD_MODEM_REGS_VH
`define QUAD_MODEM_REGS_VH

// per-channel register offsets, from the channel address bits [2:0]
`define REG_IER         3'h1
`define REG_MODEM_CTRL  3'h4
`define REG_MODEM_STAT  3'h6
`define REG_SPR         3'h7

// word index of the global pin status register on the bus
`define IDX_PIN_STATUS  6'h20

// interrupt enable field
`define IER_MODEM_BIT   3

// modem control fields
`define CTRL_DTR_BIT    0
`define CTRL_RTS_BIT    1
`define CTRL_INT_EN_BIT 3

// reset values
`define BYTE_RESET      8'h00
`define NIB_ONES        4'hf

// bus responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// upper bits of the 32-bit read word
`define RDATA_PAD       24'h000000

`endif

// file: bench/modem_host_strobe_chk.sv
`timescale 1ns/1ps
`default_nettype none
module modem_host_chk (
  // clock and reset
  input wire logic        mclk_i,
  input wire logic        rst_i,
  // mode, reset pin and bus handshakes
  input wire logic        bus_primary_i,
  input wire logic        reset_pin_i,
  input wire logic        awvalid_i,
  input wire logic        wvalid_i,
  input wire logic        awready_o,
  input wire logic        wready_o,
  input wire logic        bvalid_o,
  input wire logic        arvalid_i,
  input wire logic        arready_o,
  input wire logic        rready_i,
  input wire logic        rvalid_o,
  input wire logic [31:0] rdata_o,
  // channel pins
  input wire logic [3:0]  dtr_n_o,
  input wire logic [3:0]  rts_n_o,
  input wire logic [3:0]  tx_o,
  input wire logic [3:0]  int_o,
  input wire logic [3:0]  int_oe_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_wtake;
    awvalid_i && awready_o && wvalid_i && wready_o;
  endsequence
  // a colliding host write may push the answer back by one edge
  sequence s_wans;
    !awready_o ##[1:2] bvalid_o;
  endsequence
  property p_wr_resp;
    s_wtake |=> s_wans;
  endproperty
  property p_tx_idle;
    tx_o == 4'hf;
  endproperty
  property p_rst_outs;
    disable iff (1'b0) rst_i |=> dtr_n_o == 4'hf && rts_n_o == 4'hf && int_oe_o == 4'h0;
  endproperty
  property p_pin_pri;
    (bus_primary_i && reset_pin_i) [*4] |=> dtr_n_o == 4'hf && rts_n_o == 4'hf;
  endproperty
  property p_pin_alt;
    (!bus_primary_i && !reset_pin_i) [*4] |=> dtr_n_o == 4'hf && rts_n_o == 4'hf;
  endproperty
  property p_rd_resp;
    arvalid_i && arready_o |=> rvalid_o && !arready_o && rdata_o[31:8] == 24'h000000;
  endproperty
  property p_rd_hold;
    rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o);
  endproperty
  property p_alt_noint;
    (!bus_primary_i) [*5] |-> int_o == 4'h0 && int_oe_o == 4'h0;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
  a_tx_idle: assert property (p_tx_idle) else $error("serial out not idle");
  a_rst_outs: assert property (p_rst_outs) else $error("outputs not reset");
  a_pin_pri: assert property (p_pin_pri) else $error("high reset pin ignored");
  a_pin_alt: assert property (p_pin_alt) else $error("low reset pin ignored");
  a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_alt_noint: assert property (p_alt_noint) else $error("int pins active");
endmodule
bind modem_host_strobe modem_host_chk u_chk (.mclk_i, .rst_i, .bus_primary_i, .reset_pin_i,
  .awvalid_i, .wvalid_i, .awready_o, .wready_o, .bvalid_o, .arvalid_i, .arready_o, .rready_i,
  .rvalid_o, .rdata_o, .dtr_n_o, .rts_n_o, .tx_o, .int_o, .int_oe_o);
`default_nettype wire

// file: bench/modem_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module modem_far_end (
  // clock
  input  wire logic        mclk_i,
  // levels wanted: rx, carrier_detect_n, ring_indicator_n, dsr_n, cts_n
  input  wire logic [19:0] want_i,
  output logic      [19:0] pins_o
);
  initial pins_o = 20'h0ffff;
  // pins lag the bench by one edge, as a modem would
  always @(posedge mclk_i) begin
    pins_o <= want_i;
  end
endmodule
`default_nettype wire

// file: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "quad_modem_regs.vh"
module tb_top;
  logic        mclk_i, rst_i, bus_primary_i, reset_pin_i, chip_select_n_i, rw_strobe_i;
  logic        awvalid_i, awready_o, wvalid_i, wready_o, bvalid_o, bready_i;
  logic        arvalid_i, arready_o, rvalid_o, rready_i, host_data_bus_oe_o, irq_n_o;
  logic [4:0]  register_channel_address_i;
  logic [7:0]  host_data_bus_i, host_data_bus_o, hdrv, awaddr_i, araddr_i, rd, a;
  logic [31:0] wdata_i, rdata_o;
  logic [1:0]  bresp_o, rresp_o, resp;
  logic [3:0]  cts_n_i, dsr_n_i, ring_indicator_n_i, carrier_detect_n_i, rx_i;
  logic [3:0]  dtr_n_o, rts_n_o, tx_o, int_o, int_oe_o;
  logic [19:0] want;
  logic        intsel_i;
  int          n_mismatch, check_count;
  int          cyc = 0;
  assign host_data_bus_i = host_data_bus_oe_o ? host_data_bus_o : hdrv;
  modem_host_strobe u_dut (
    .mclk_i, .rst_i, .bus_primary_i, .reset_pin_i, .intsel_i, .chip_select_n_i,
    .register_channel_address_i, .rw_strobe_i, .host_data_bus_i, .host_data_bus_o,
    .host_data_bus_oe_o, .awvalid_i, .awaddr_i, .awready_o, .wvalid_i, .wdata_i,
    .wstrb_i(4'h1), .wready_o, .bvalid_o, .bresp_o, .bready_i, .arvalid_i, .araddr_i,
    .arready_o, .rvalid_o, .rdata_o, .rresp_o, .rready_i, .cts_n_i, .dsr_n_i,
    .ring_indicator_n_i, .carrier_detect_n_i, .rx_i, .dtr_n_o, .rts_n_o, .tx_o, .int_o,
    .int_oe_o, .irq_n_o
  );
  modem_far_end u_far (.mclk_i, .want_i(want), .pins_o({rx_i, carrier_detect_n_i,
    ring_indicator_n_i, dsr_n_i, cts_n_i}));
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [7:0] ad, input logic [7:0] d);
    awaddr_i <= ad;
    wdata_i <= {24'h000000, d};
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (awready_o) awvalid_i <= 1'b0;
      if (wready_o) wvalid_i <= 1'b0;
    end while (!bvalid_o);
    // bready stays high between writes, so back-to-back calls never toggle it in one step
    resp = bresp_o;
  endtask
  // rready comes late on purpose so the slave must hold its answer
  task automatic axr(input logic [7:0] ad);
    araddr_i <= ad;
    arvalid_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (arready_o) arvalid_i <= 1'b0;
      if (rvalid_o && !rready_i) rready_i <= 1'b1;
    end while (!(rvalid_o && rready_i));
    rd = rdata_o[7:0];
    resp = rresp_o;
    rready_i <= 1'b0;
  endtask
  // fall writes d, rise reads the same place back
  task automatic host(input logic [4:0] ad, input logic [7:0] d);
    chip_select_n_i <= 1'b0;
    register_channel_address_i <= ad;
    hdrv <= d;
    tick(2);
    rw_strobe_i <= 1'b0;
    tick(4);
    rw_strobe_i <= 1'b1;
    tick(4);
    chk(host_data_bus_oe_o, 1'b1);
    chk(host_data_bus_o, d);
    chip_select_n_i <= 1'b1;
    hdrv <= ~d;
    tick(4);
    chk(host_data_bus_oe_o, 1'b0);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    {rst_i, bus_primary_i, reset_pin_i, chip_select_n_i, rw_strobe_i} = 5'h1b;
    {awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i, intsel_i} = 6'h00;
    {register_channel_address_i, hdrv, awaddr_i, araddr_i, wdata_i} = '0;
    {want, n_mismatch, check_count} = {20'h0ffff, 64'h0};
    tick(8);
    rst_i <= 1'b0;
    tick(5);
    chk({dtr_n_o, rts_n_o, tx_o}, 12'hfff);
    for (int c = 0; c < 4; c++) begin
      a = 8'h10 + 8'(c * 32);
      axr(a);
      chk(rd, 8'h00);
      axw(a, 8'h03);
      tick(2);
      chk({dtr_n_o, rts_n_o}, {2{4'(~(4'h1 << c))}});
      axw(a, 8'h02);
      tick(2);
      chk({dtr_n_o, rts_n_o}, {4'hf, 4'(~(4'h1 << c))});
      axw(a, 8'h00);
    end
    intsel_i <= 1'b1;
    tick(4);
    chk(int_oe_o, 4'hf);
    intsel_i <= 1'b0;
    axw(8'h24, 8'h08);
    axw(8'h30, 8'h08);
    tick(2);
    chk(int_oe_o, 4'h2);
    axr(8'h38);
    want[13] <= 1'b0;
    want[1] <= 1'b0;
    tick(6);
    chk(int_o, 4'h2);
    axr(8'h38);
    chk(rd, 8'h99);
    axr(8'h38);
    chk(rd, 8'h90);
    want[9] <= 1'b0;
    want[5] <= 1'b0;
    tick(6);
    axr(8'h38);
    chk(rd, 8'hf2);
    tick(4);
    chk(int_o, 4'h0);
    want[9] <= 1'b1;
    tick(6);
    chk(int_o, 4'h2);
    axr(8'h38);
    chk(rd, 8'hb4);
    chk({tx_o, dtr_n_o}, 8'hff);
    axr(8'h00);
    chk(resp, `RESP_SLVERR);
    axw(8'h10, 8'h01);
    reset_pin_i <= 1'b1;
    tick(5);
    chk(dtr_n_o, 4'hf);
    axr(8'h80);
    chk(rd, 8'hf3);
    reset_pin_i <= 1'b0;
    tick(5);
    axr(8'h10);
    chk(rd, 8'h00);
    axr(8'h80);
    chk(rd, 8'h01);
    bus_primary_i <= 1'b0;
    reset_pin_i <= 1'b1;
    tick(6);
    chk(int_oe_o, 4'h0);
    host(5'h17, 8'h5a);
    axr(8'h5c);
    chk(rd, 8'h5a);
    host(5'h14, 8'h01);
    chk(dtr_n_o, 4'hb);
    axw(8'h24, 8'h08);
    chk(resp, `RESP_OKAY);
    want[1] <= 1'b1;
    tick(6);
    chk({irq_n_o, int_o}, 5'h00);
    axr(8'h38);
    chk(rd, 8'ha1);
    chk(irq_n_o, 1'b1);
    reset_pin_i <= 1'b0;
    tick(5);
    chk(dtr_n_o, 4'hf);
    reset_pin_i <= 1'b1;
    tick(5);
    axr(8'h50);
    chk(rd, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
